// file: common/spt_pkg.sv
// Shared constants and types for the SPI target port
package spt_pkg;

  // Word and buffer geometry
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W      = 5;
  localparam int PER_W      = 9;

  // Global control register field
  localparam int CTL_CTRL_SEL_BIT = 0;

  // Format register fields
  localparam int FMT_PRESCALE_LSB = 8;
  localparam int FMT_PRESCALE_MSB = 15;
  localparam int FMT_PHASE_BIT    = 16;
  localparam int FMT_POLARITY_BIT = 17;

  // Reset values
  localparam logic [WORD_W-1:0] RX_DATA_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  BIT_CNT_RST = 5'h00;
  localparam logic [PER_W-1:0]  PER_MAX     = 9'h1ff;

  // Timing: core clock period and least serial clock period
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int MIN_SCLK_PERIOD_NS = 25;
  localparam int MIN_SCLK_CYC_INT   = (MIN_SCLK_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam logic [PER_W-1:0] MIN_SCLK_CYC = PER_W'(MIN_SCLK_CYC_INT);

  // Decoded format
  typedef struct packed {
    logic       polarity;
    logic       phase;
    logic [7:0] prescale;
  } spt_fmt_t;

  // Received word
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } spt_rx_t;

  // Least serial clock period in core cycles for a prescale value
  function automatic logic [PER_W-1:0] min_period(input logic [7:0] ps);
    logic [PER_W-1:0] p;
    p = (ps == 8'h00) ? 9'h002 : ({1'b0, ps} + 9'h001);
    return (p > MIN_SCLK_CYC) ? p : MIN_SCLK_CYC;
  endfunction

endpackage

// file: design/spt_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module spt_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             rdy_q, rdy_d, val_q, val_d;
  logic             push, pop;

  always_comb begin
    push  = in_valid_i & rdy_q;
    pop   = out_ready_i & val_q;
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    rdy_d = cnt_d != (AW+1)'(DEPTH);
    val_d = cnt_d != '0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      val_q <= 1'b0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      val_q <= val_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  assign in_ready_o  = rdy_q;
  assign out_valid_o = val_q;
  assign out_data_o  = mem[rp_q];

endmodule // spt_fifo
`default_nettype wire

// file: design/spt_target.sv
// SPI target port: serial shifter, frame control and transmit buffer
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Target mode, serial clock as input, when control bit 0 is clear.
// - Format bit 16 selects clock phase, changing launch/sample edge pairing.
// - Format bit 17 selects clock polarity; together with phase it decides the active edge.
// - Prescale bits 15:8 set least serial period; never under 25 ns.
// - Polarity equal to phase: output bits launched after rising edges.
// - Polarity differing from phase: output bits launched after falling edges.
// - Equal settings sample on falling edge, otherwise on rising edge.
module spt_target #(
  parameter int WORD_W = spt_pkg::WORD_W,
  parameter int DEPTH  = spt_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              RESET_N_I,
  // Configuration
  input  wire logic [31:0]       GLOBAL_CONTROL_REG_I,
  input  wire logic [31:0]       FORMAT_REG_I,
  // Serial pins
  input  wire logic              SERIAL_CLOCK_PIN_I,
  input  wire logic              CS_N_I,
  input  wire logic              TARGET_DATA_IN_I,
  output logic                   TARGET_DATA_OUT_O,
  output logic                   TARGET_DATA_OUT_OE_O,
  // Transmit words
  input  wire logic              TX_VALID_I,
  input  wire logic [WORD_W-1:0] TX_DATA_I,
  output logic                   TX_READY_O,
  // Received words and status
  output logic                   RX_VALID_O,
  output logic [WORD_W-1:0]      RX_DATA_O,
  output logic                   RATE_ERR_O
);
  localparam int CW = spt_pkg::CNT_W;

  logic rst_s1_q, rst_s2_q, rst_n;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Configuration decode
  spt_pkg::spt_fmt_t fmt;
  logic              ctrl_sel;

  always_comb begin
    fmt.polarity = FORMAT_REG_I[spt_pkg::FMT_POLARITY_BIT];
    fmt.phase    = FORMAT_REG_I[spt_pkg::FMT_PHASE_BIT];
    fmt.prescale = FORMAT_REG_I[spt_pkg::FMT_PRESCALE_MSB:spt_pkg::FMT_PRESCALE_LSB];
    ctrl_sel     = GLOBAL_CONTROL_REG_I[spt_pkg::CTL_CTRL_SEL_BIT];
  end

  // Transmit buffer
  logic              fifo_valid, fifo_pop;
  logic [WORD_W-1:0] fifo_data;

  spt_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (rst_n),
    .in_valid_i  (TX_VALID_I),
    .in_data_i   (TX_DATA_I),
    .in_ready_o  (TX_READY_O),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  // Edge and frame detection
  logic sclk_q, cs_n_q;
  logic rise, fall, mode_b, sample_ev, launch_ev, active, frame_start;

  always_comb begin
    rise        = SERIAL_CLOCK_PIN_I & ~sclk_q;
    fall        = ~SERIAL_CLOCK_PIN_I & sclk_q;
    mode_b      = fmt.polarity ^ fmt.phase;
    sample_ev   = mode_b ? rise : fall;
    launch_ev   = mode_b ? fall : rise;
    active      = ~CS_N_I & ~ctrl_sel;
    frame_start = cs_n_q & ~CS_N_I & ~ctrl_sel;
    fifo_pop    = frame_start & fifo_valid;
  end

  // Shifter state
  logic [WORD_W-1:0]       tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [CW-1:0]           bit_cnt_q, bit_cnt_d;
  logic [spt_pkg::PER_W-1:0] per_q, per_d;
  spt_pkg::spt_rx_t        rx_q, rx_d;
  logic                    oe_q, oe_d, err_q, err_d;

  // Gap counter holds the serial period less one when the next sample edge arrives
  function automatic logic [spt_pkg::PER_W-1:0] gap_floor(input logic [7:0] ps);
    return spt_pkg::PER_W'(spt_pkg::min_period(ps) - 1'b1);
  endfunction

  always_comb begin
    tx_sh_d   = tx_sh_q;
    rx_sh_d   = rx_sh_q;
    bit_cnt_d = bit_cnt_q;
    rx_d      = rx_q;
    rx_d.valid = 1'b0;
    err_d     = err_q;
    oe_d      = active;
    per_d     = (per_q == spt_pkg::PER_MAX) ? per_q : spt_pkg::PER_W'(per_q + 1'b1);
    if (!active) begin
      bit_cnt_d = spt_pkg::BIT_CNT_RST;
      per_d     = spt_pkg::PER_MAX;
    end else if (frame_start) begin
      tx_sh_d   = fifo_valid ? fifo_data : '0;
      bit_cnt_d = spt_pkg::BIT_CNT_RST;
      per_d     = spt_pkg::PER_MAX;
      err_d     = 1'b0;
    end else if (bit_cnt_q < CW'(WORD_W)) begin
      if (sample_ev) begin
        rx_sh_d   = {rx_sh_q[WORD_W-2:0], TARGET_DATA_IN_I};
        bit_cnt_d = CW'(bit_cnt_q + 1'b1);
        per_d     = '0;
        if (per_q < gap_floor(fmt.prescale)) begin
          err_d = 1'b1;
        end
        if (bit_cnt_q == CW'(WORD_W - 1)) begin
          rx_d.valid = 1'b1;
          rx_d.data  = {rx_sh_q[WORD_W-2:0], TARGET_DATA_IN_I};
        end
      end else if (launch_ev && bit_cnt_q != '0) begin
        tx_sh_d = {tx_sh_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q    <= 1'b0;
      cs_n_q    <= 1'b1;
      tx_sh_q   <= '0;
      rx_sh_q   <= '0;
      bit_cnt_q <= spt_pkg::BIT_CNT_RST;
      per_q     <= spt_pkg::PER_MAX;
      rx_q      <= '{valid: 1'b0, data: spt_pkg::RX_DATA_RST};
      oe_q      <= 1'b0;
      err_q     <= 1'b0;
    end else begin
      sclk_q    <= SERIAL_CLOCK_PIN_I;
      cs_n_q    <= CS_N_I;
      tx_sh_q   <= tx_sh_d;
      rx_sh_q   <= rx_sh_d;
      bit_cnt_q <= bit_cnt_d;
      per_q     <= per_d;
      rx_q      <= rx_d;
      oe_q      <= oe_d;
      err_q     <= err_d;
    end
  end

  assign TARGET_DATA_OUT_O    = tx_sh_q[WORD_W-1];
  assign TARGET_DATA_OUT_OE_O = oe_q;
  assign RX_VALID_O           = rx_q.valid;
  assign RX_DATA_O            = rx_q.data;
  assign RATE_ERR_O           = err_q;

  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_frame_open;
    cs_n_q && !CS_N_I && !ctrl_sel;
  endsequence

  sequence s_last_sample;
    active && !frame_start && sample_ev && bit_cnt_q == CW'(WORD_W - 1);
  endsequence

  AST_CTRL_OFF: assert property (ctrl_sel |=> !TARGET_DATA_OUT_OE_O)
    else $error("Output enabled while controller select is set");

  AST_CS_CLEARS: assert property (CS_N_I |=> bit_cnt_q == '0 && !RX_VALID_O)
    else $error("Bit counter not cleared with chip select high");

  AST_SAMPLE_STEP: assert property (active && !frame_start && sample_ev && bit_cnt_q < CW'(WORD_W)
    |=> bit_cnt_q == CW'($past(bit_cnt_q) + 1'b1))
    else $error("Sample edge did not advance the bit counter");

  AST_MODE_EQ_RISE: assert property (active && !frame_start && !mode_b && rise |=> $stable(bit_cnt_q))
    else $error("Rising edge sampled with equal polarity and phase");

  AST_MODE_NE_FALL: assert property (active && !frame_start && mode_b && fall |=> $stable(bit_cnt_q))
    else $error("Falling edge sampled with differing polarity and phase");

  AST_LAUNCH: assert property (active && !frame_start && launch_ev && !sample_ev && bit_cnt_q != '0
    && bit_cnt_q < CW'(WORD_W) |=> TARGET_DATA_OUT_O == $past(tx_sh_q[WORD_W-2]))
    else $error("Next bit not launched on launch edge");

  AST_WORD_DONE: assert property (s_last_sample |=> RX_VALID_O
    && RX_DATA_O == {$past(rx_sh_q[WORD_W-2:0]), $past(TARGET_DATA_IN_I)} ##1 !RX_VALID_O)
    else $error("Received word not presented after sixteenth sample");

  AST_FIRST_BIT: assert property (s_frame_open ##0 fifo_valid |=> TARGET_DATA_OUT_O == $past(fifo_data[WORD_W-1])
    && TARGET_DATA_OUT_OE_O)
    else $error("First bit not presented at frame start");

  AST_RATE: assert property (active && !frame_start && sample_ev && bit_cnt_q < CW'(WORD_W)
    && per_q < gap_floor(fmt.prescale) |=> RATE_ERR_O)
    else $error("Too fast serial clock not flagged");

endmodule // spt_target
`default_nettype wire

// file: testbench/spt_host_model.sv
// Host-side SPI controller model that drives the target's serial pins
`timescale 1ns/1ns
`default_nettype none
module spt_host_model (
  // Core clock and target output
  input  wire logic clk_i,
  input  wire logic dout_i,
  // Serial pins toward the target
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One frame: n sample edges, half period h core cycles
  task automatic xfer(input logic pol, input logic pha, input int h, input int n,
                      input logic [15:0] wo, output logic [15:0] wi);
    int   k;
    logic s;
    k  = 0;
    s  = pol;
    wi = 16'h0000;
    @(posedge clk_i);
    sclk_o <= pol;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4 * h) @(posedge clk_i);
    while (k < n || s != pol) begin
      if (k < n && (~s) == (pol ^ pha)) begin
        mosi_o <= wo[15-k];
        repeat (h) @(posedge clk_i);
        wi = {wi[14:0], dout_i};
        k++;
      end else begin
        repeat (h) @(posedge clk_i);
      end
      s = ~s;
      sclk_o <= s;
    end
    repeat (h) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // Released data line no longer shows the last bit
    mosi_o <= ~mosi_o;
    repeat (h) @(posedge clk_i);
  endtask
endmodule // spt_host_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the SPI target port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk, rst_n, sclk, cs_n, mosi, dout, oe;
  logic        tx_valid, tx_ready, rx_valid, rate_err;
  logic [31:0] gcr, fmt;
  logic [15:0] tx_data, rx_data, rx_last, got;
  int          fails, total_checks;
  int          rx_cnt = 0;
  int          oe_cnt = 0;

  spt_target dut_u (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .GLOBAL_CONTROL_REG_I(gcr),
    .FORMAT_REG_I(fmt), .SERIAL_CLOCK_PIN_I(sclk), .CS_N_I(cs_n), .TARGET_DATA_IN_I(mosi),
    .TARGET_DATA_OUT_O(dout), .TARGET_DATA_OUT_OE_O(oe), .TX_VALID_I(tx_valid),
    .TX_DATA_I(tx_data), .TX_READY_O(tx_ready), .RX_VALID_O(rx_valid),
    .RX_DATA_O(rx_data), .RATE_ERR_O(rate_err));
  spt_host_model host_u (.clk_i(clk), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts received-word pulses and driven cycles
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt  <= rx_cnt + 1;
      rx_last <= rx_data;
    end
    if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end

  task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_b(input logic e, input logic g);
    chk_w({15'h0000, e}, {15'h0000, g});
  endtask

  task automatic end_sim();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic push(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data  <= w;
    do @(posedge clk); while (tx_ready !== 1'b1 && n++ < 50);
    chk_b(1'b1, tx_ready);
    tx_valid <= 1'b0;
  endtask

  task automatic set_fmt(input logic pol, input logic pha, input logic [7:0] ps);
    @(posedge clk);
    fmt <= {14'h0000, pol, pha, ps, 8'h00};
  endtask

  task automatic t_reset();
    chk_b(1'b0, oe);
    chk_b(1'b1, tx_ready);
    chk_b(1'b0, rx_valid);
    chk_w(spt_pkg::RX_DATA_RST, rx_data);
    $display("test reset done");
  endtask

  task automatic t_modes();
    int c, o;
    for (int m = 0; m < 4; m++) begin
      set_fmt(m[1], m[0], 8'h05);
      push(16'ha5c3 ^ 16'(m));
      c = rx_cnt;
      o = oe_cnt;
      host_u.xfer(m[1], m[0], 4, 16, 16'h3c5a + 16'(m), got);
      chk_w(16'ha5c3 ^ 16'(m), got);
      chk_w(16'h3c5a + 16'(m), rx_last);
      chk_w(16'(c + 1), 16'(rx_cnt));
      chk_b(1'b0, rate_err);
      // Driven from one cycle after select falls to one after it rises: 37 half periods
      chk_w(16'(o + 37 * 4), 16'(oe_cnt));
    end
    $display("test modes done");
  endtask

  task automatic t_short();
    int c;
    set_fmt(1'b0, 1'b0, 8'h05);
    push(16'h1234);
    push(16'hbeef);
    c = rx_cnt;
    host_u.xfer(1'b0, 1'b0, 4, 5, 16'hffff, got);
    chk_w(16'(c), 16'(rx_cnt));
    host_u.xfer(1'b0, 1'b0, 4, 16, 16'h0f0f, got);
    chk_w(16'hbeef, got);
    chk_w(16'h0f0f, rx_last);
    host_u.xfer(1'b0, 1'b0, 4, 16, 16'h0001, got);
    chk_w(16'h0000, got);
    $display("test short done");
  endtask

  task automatic t_disable();
    int c, o;
    @(posedge clk);
    gcr <= 32'h0000_0001;
    c = rx_cnt;
    o = oe_cnt;
    host_u.xfer(1'b0, 1'b0, 4, 16, 16'h5555, got);
    chk_w(16'(c), 16'(rx_cnt));
    chk_w(16'(o), 16'(oe_cnt));
    @(posedge clk);
    gcr <= 32'h0000_0000;
    $display("test disable done");
  endtask

  task automatic t_rate();
    // Prescale 7 at an 8-cycle period sits exactly on the floor and must pass
    logic [7:0] ps [5] = '{8'h05, 8'h0a, 8'h05, 8'h07, 8'h00};
    int         hh [5] = '{2, 4, 4, 4, 4};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      set_fmt(1'b0, 1'b0, ps[i]);
      host_u.xfer(1'b0, 1'b0, hh[i], 16, 16'h00ff, got);
      chk_b(ex[i], rate_err);
    end
    $display("test rate done");
  endtask

  task automatic t_fill();
    set_fmt(1'b0, 1'b0, 8'h05);
    for (int i = 0; i < 32; i++) push(16'h1000 + 16'(i));
    repeat (2) @(posedge clk);
    chk_b(1'b0, tx_ready);
    tx_valid <= 1'b1;
    tx_data  <= 16'hdead;
    @(posedge clk);
    tx_valid <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      set_fmt(i[1], i[0], 8'h05);
      host_u.xfer(i[1], i[0], 4, 16, 16'(i), got);
      chk_w(16'h1000 + 16'(i), got);
      chk_w(16'(i), rx_last);
    end
    chk_b(1'b1, tx_ready);
    host_u.xfer(1'b1, 1'b1, 4, 16, 16'h0000, got);
    chk_w(16'h0000, got);
    $display("test fill done");
  endtask

  initial begin
    #200000;
    fails++;
    end_sim();
  end

  initial begin
    gcr = 32'h0000_0000;
    fmt = 32'h0000_0500;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    rst_n = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_modes();
    t_short();
    t_disable();
    t_rate();
    t_fill();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
